//--- hdl/spt_regs.sv
`timescale 1ns/100ps
// Functional notes
// R1 - Receiver start trigger begins receiving into the receive buffer.
// R2 - Receiver stop trigger stops the receiver.
// R3 - Transmitter start trigger begins sending the transmit buffer.
// R4 - Transmitter stop trigger stops the transmitter.
// R5 - Drain trigger moves leftover receive FIFO bytes into memory.
// R6 - Channel link holds channel index and enable; enabled channel events trigger the task.
// R7 - Channel links exist for each task at distinct offsets.
// R8 - Peer ready flag sets when clear-to-send falls low.
// R9 - Peer not ready flag sets when clear-to-send returns high.
// R10 - Byte received flag sets when a byte reaches the holding stage.
// R11 - Receive buffer full flag sets when the memory buffer is filled.
// R12 - Transmit done flag sets after the last buffer byte is sent.
// R13 - Event flags read 1 after event, reset 0, cleared by writing 0.
// R14 - Writing 1 to a task triggers it; tasks are write-only, 0 ignored.
module spt_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [255:0] channelEvents,
	input wire logic ctsPin_n,
	input wire logic rxByteLanded,
	input wire logic rxBufferFilled,
	input wire logic txByteSent,
	input wire logic txLastByteSent,
	output logic rxStartPulse,
	output logic rxStopPulse,
	output logic txStartPulse,
	output logic txStopPulse,
	output logic rxDrainPulse,
	output logic rxRunning,
	output logic txRunning,
	output logic irq
);
	typedef struct packed {
		logic awHeld;
		logic [11:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic [spt_pkg::NUM_TASKS-1:0][31:0] link;
		logic [spt_pkg::NUM_EVENTS-1:0] flags;
		logic [spt_pkg::NUM_EVENTS-1:0] irqStat;
		logic [spt_pkg::NUM_EVENTS-1:0] irqMask;
		logic [spt_pkg::NUM_TASKS-1:0] taskPulse;
		logic rxRun;
		logic txRun;
		logic cts1;
		logic cts2;
		logic cts3;
		logic [3:0] evSync1;
		logic [3:0] evSync2;
		logic [3:0] evSync3;
	} spt_state_t;

	spt_state_t s_q;
	spt_state_t s_d;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Returns the task index of a trigger address, or NUM_TASKS when none.
	function automatic int trigIdx(input logic [11:0] a);
		int r;
		r = spt_pkg::NUM_TASKS;
		unique case (a)
			spt_pkg::RX_START_TRIGGER: r = spt_pkg::T_RXSTART;
			spt_pkg::RX_STOP_TRIGGER: r = spt_pkg::T_RXSTOP;
			spt_pkg::TX_START_TRIGGER: r = spt_pkg::T_TXSTART;
			spt_pkg::TX_STOP_TRIGGER: r = spt_pkg::T_TXSTOP;
			spt_pkg::RX_FIFO_DRAIN_TRIGGER: r = spt_pkg::T_DRAIN;
			default: r = spt_pkg::NUM_TASKS;
		endcase
		return r;
	endfunction

	// Returns the task index of a channel link address, or NUM_TASKS when none.
	function automatic int linkIdx(input logic [11:0] a);
		int r;
		r = spt_pkg::NUM_TASKS;
		unique case (a)
			spt_pkg::RX_START_CHANNEL_LINK: r = spt_pkg::T_RXSTART;
			spt_pkg::RX_STOP_CHANNEL_LINK: r = spt_pkg::T_RXSTOP;
			spt_pkg::TX_START_CHANNEL_LINK: r = spt_pkg::T_TXSTART;
			spt_pkg::TX_STOP_CHANNEL_LINK: r = spt_pkg::T_TXSTOP;
			spt_pkg::RX_DRAIN_CHANNEL_LINK: r = spt_pkg::T_DRAIN;
			default: r = spt_pkg::NUM_TASKS;
		endcase
		return r;
	endfunction

	function automatic int eventIdx(input logic [11:0] a);
		int r;
		r = spt_pkg::NUM_EVENTS;
		unique case (a)
			spt_pkg::PEER_READY_FLAG: r = spt_pkg::E_READY;
			spt_pkg::PEER_NOT_READY_FLAG: r = spt_pkg::E_NOTREADY;
			spt_pkg::BYTE_RECEIVED_FLAG: r = spt_pkg::E_RXBYTE;
			spt_pkg::RX_BUFFER_FULL_FLAG: r = spt_pkg::E_RXFULL;
			spt_pkg::BYTE_SENT_FLAG: r = spt_pkg::E_TXBYTE;
			spt_pkg::TX_DONE_FLAG: r = spt_pkg::E_TXDONE;
			default: r = spt_pkg::NUM_EVENTS;
		endcase
		return r;
	endfunction

	// A strobe counts once per rise, so a strobe held high does not repeat its event.
	function automatic logic rose(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	function automatic logic isMapped(input logic [11:0] a);
		return trigIdx(a) < spt_pkg::NUM_TASKS || linkIdx(a) < spt_pkg::NUM_TASKS ||
			eventIdx(a) < spt_pkg::NUM_EVENTS || a == spt_pkg::IRQ_STATUS ||
			a == spt_pkg::IRQ_MASK || a == spt_pkg::PORT_STATE;
	endfunction

	// Reserved link bits are kept as written; only the index and the enable act.
	function automatic logic linkFires(input logic [31:0] link,
		input logic [255:0] ev);
		return link[spt_pkg::LINK_EN_BIT] && ev[link[spt_pkg::CH_BITS-1:0]];
	endfunction

	// Task and unmapped addresses both read zero; only the response tells them apart.
	function automatic logic [31:0] readWord(input logic [11:0] a, input spt_state_t q);
		logic [31:0] r;
		int ti;
		int ei;
		r = '0;
		ti = linkIdx(a);
		ei = eventIdx(a);
		if (trigIdx(a) < spt_pkg::NUM_TASKS) begin
			r = '0; // R14
		end else if (ti < spt_pkg::NUM_TASKS) begin
			r = q.link[ti];
		end else if (ei < spt_pkg::NUM_EVENTS) begin
			r = {31'h0, q.flags[ei]}; // R13
		end else if (a == spt_pkg::IRQ_STATUS) begin
			r = 32'(q.irqStat);
		end else if (a == spt_pkg::IRQ_MASK) begin
			r = 32'(q.irqMask);
		end else if (a == spt_pkg::PORT_STATE) begin
			r = {29'h0, q.cts2, q.txRun, q.rxRun};
		end
		return r;
	endfunction

	always_comb begin
		logic doWrite;
		logic doRead;
		logic [spt_pkg::NUM_EVENTS-1:0] evt;
		logic [spt_pkg::NUM_EVENTS-1:0] clr;
		logic [spt_pkg::NUM_TASKS-1:0] trig;
		logic hit;
		logic statusRead;
		int ti;
		int ei;
		statusRead = 1'b0;
		doWrite = 1'b0;
		doRead = 1'b0;
		evt = '0;
		clr = '0;
		trig = '0;
		hit = 1'b0;
		ti = 0;
		ei = 0;
		s_d = s_q;
		// Pin and line-side strobes pass two flops before any logic looks at them.
		s_d.cts1 = ctsPin_n;
		s_d.cts2 = s_q.cts1;
		s_d.cts3 = s_q.cts2;
		s_d.evSync1[0] = rxByteLanded;
		s_d.evSync1[1] = rxBufferFilled;
		s_d.evSync1[2] = txByteSent;
		s_d.evSync1[3] = txLastByteSent;
		s_d.evSync2 = s_q.evSync1;
		s_d.evSync3 = s_q.evSync2;
		evt[spt_pkg::E_READY] = rose(s_q.cts3, s_q.cts2); // R8
		evt[spt_pkg::E_NOTREADY] = rose(s_q.cts2, s_q.cts3); // R9
		evt[spt_pkg::E_RXBYTE] = rose(s_q.evSync2[0], s_q.evSync3[0]); // R10
		evt[spt_pkg::E_RXFULL] = rose(s_q.evSync2[1], s_q.evSync3[1]); // R11
		evt[spt_pkg::E_TXBYTE] = rose(s_q.evSync2[2], s_q.evSync3[2]);
		evt[spt_pkg::E_TXDONE] = rose(s_q.evSync2[3], s_q.evSync3[3]); // R12

		// Write channels are taken independently and held until both are present.
		// A channel frees as soon as its write is done, so the next one may queue
		// behind a response that the master has not yet taken.
		if (s_axi_awvalid && !s_q.awHeld) begin
			s_d.awHeld = 1'b1;
			s_d.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.wHeld) begin
			s_d.wHeld = 1'b1;
			s_d.wData = s_axi_wdata;
			s_d.wStrb = s_axi_wstrb;
		end
		if (s_q.bValid && s_axi_bready) begin
			s_d.bValid = 1'b0;
		end
		if (s_q.awHeld && s_q.wHeld && !s_q.bValid) begin
			doWrite = 1'b1;
			s_d.awHeld = 1'b0;
			s_d.wHeld = 1'b0;
			s_d.bValid = 1'b1;
		end
		if (doWrite) begin
			// The trigger bit needs its byte lane; a write that misses lane 0 does nothing.
			ti = trigIdx(s_q.awAddr);
			if (ti < spt_pkg::NUM_TASKS) begin
				hit = 1'b1;
				trig[ti] = s_q.wData[0] & s_q.wStrb[0]; // R14
			end
			ti = linkIdx(s_q.awAddr);
			if (ti < spt_pkg::NUM_TASKS) begin
				hit = 1'b1;
				s_d.link[ti] = wmerge(s_q.link[ti], s_q.wData, s_q.wStrb); // R6 R7
			end
			ei = eventIdx(s_q.awAddr);
			if (ei < spt_pkg::NUM_EVENTS) begin
				hit = 1'b1;
				clr[ei] = s_q.wStrb[0] & ~s_q.wData[0]; // R13
			end
			if (s_q.awAddr == spt_pkg::IRQ_MASK) begin
				hit = 1'b1;
				if (s_q.wStrb[0]) begin
					s_d.irqMask = s_q.wData[spt_pkg::NUM_EVENTS-1:0];
				end
			end
			if (s_q.awAddr == spt_pkg::IRQ_STATUS || s_q.awAddr == spt_pkg::PORT_STATE) begin
				hit = 1'b1;
			end
			s_d.bResp = hit ? spt_pkg::RESP_OKAY : spt_pkg::RESP_SLVERR;
		end

		// An enabled link fires its task on an event of the chosen channel.
		for (int t = 0; t < spt_pkg::NUM_TASKS; t++) begin
			if (linkFires(s_q.link[t], channelEvents)) begin
				trig[t] = 1'b1; // R6
			end
		end
		s_d.taskPulse = trig;
		// Stop wins over a start in the same cycle so software can always halt the port.
		if (trig[spt_pkg::T_RXSTART]) begin
			s_d.rxRun = 1'b1; // R1
		end
		if (trig[spt_pkg::T_RXSTOP]) begin
			s_d.rxRun = 1'b0; // R2
		end
		if (trig[spt_pkg::T_TXSTART]) begin
			s_d.txRun = 1'b1; // R3
		end
		if (trig[spt_pkg::T_TXSTOP] || evt[spt_pkg::E_TXDONE]) begin
			s_d.txRun = 1'b0; // R4
		end
		// A full buffer ends reception, as the last byte ends transmission.
		if (evt[spt_pkg::E_RXFULL]) begin
			s_d.rxRun = 1'b0;
		end

		if (s_q.rValid && s_axi_rready) begin
			s_d.rValid = 1'b0;
		end
		if (s_axi_arvalid && !s_q.rValid) begin
			doRead = 1'b1;
			s_d.rValid = 1'b1;
			s_d.rData = readWord(s_axi_araddr, s_q);
			if (isMapped(s_axi_araddr)) begin
				s_d.rResp = spt_pkg::RESP_OKAY;
			end else begin
				s_d.rResp = spt_pkg::RESP_SLVERR;
			end
		end

		// Hardware set wins over a clear landing in the same cycle.
		s_d.flags = (s_q.flags & ~clr) | evt; // R13
		// A status read clears only what it has shown; an event in that cycle still lands.
		statusRead = doRead && s_axi_araddr == spt_pkg::IRQ_STATUS;
		s_d.irqStat = (statusRead ? '0 : s_q.irqStat) | evt;

		// The clear-to-send synchronisers reset to the idle high of the pin, so release shows no false edge.
		if (!rst_n) begin
			s_d = '0;
			s_d.cts1 = 1'b1;
			s_d.cts2 = 1'b1;
			s_d.cts3 = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	assign s_axi_awready = !s_q.awHeld;
	assign s_axi_wready = !s_q.wHeld;
	assign s_axi_bvalid = s_q.bValid;
	assign s_axi_bresp = s_q.bResp;
	assign s_axi_arready = !s_q.rValid;
	assign s_axi_rvalid = s_q.rValid;
	assign s_axi_rdata = s_q.rData;
	assign s_axi_rresp = s_q.rResp;

	assign rxStartPulse = s_q.taskPulse[spt_pkg::T_RXSTART];
	assign rxStopPulse = s_q.taskPulse[spt_pkg::T_RXSTOP];
	assign txStartPulse = s_q.taskPulse[spt_pkg::T_TXSTART];
	assign txStopPulse = s_q.taskPulse[spt_pkg::T_TXSTOP];
	assign rxDrainPulse = s_q.taskPulse[spt_pkg::T_DRAIN]; // R5

	assign rxRunning = s_q.rxRun;
	assign txRunning = s_q.txRun;
	assign irq = |(s_q.irqStat & s_q.irqMask);
endmodule

//--- hdl/spt_pkg.sv
package spt_pkg;
	localparam logic [11:0] RX_START_TRIGGER = 12'h000;
	localparam logic [11:0] RX_STOP_TRIGGER = 12'h004;
	localparam logic [11:0] TX_START_TRIGGER = 12'h008;
	localparam logic [11:0] TX_STOP_TRIGGER = 12'h00c;
	localparam logic [11:0] RX_FIFO_DRAIN_TRIGGER = 12'h02c;
	localparam logic [11:0] RX_START_CHANNEL_LINK = 12'h080;
	localparam logic [11:0] RX_STOP_CHANNEL_LINK = 12'h084;
	localparam logic [11:0] TX_START_CHANNEL_LINK = 12'h088;
	localparam logic [11:0] TX_STOP_CHANNEL_LINK = 12'h08c;
	localparam logic [11:0] RX_DRAIN_CHANNEL_LINK = 12'h0ac;
	localparam logic [11:0] PEER_READY_FLAG = 12'h100;
	localparam logic [11:0] PEER_NOT_READY_FLAG = 12'h104;
	localparam logic [11:0] BYTE_RECEIVED_FLAG = 12'h108;
	localparam logic [11:0] RX_BUFFER_FULL_FLAG = 12'h110;
	localparam logic [11:0] BYTE_SENT_FLAG = 12'h11c;
	localparam logic [11:0] TX_DONE_FLAG = 12'h120;
	localparam logic [11:0] IRQ_STATUS = 12'h400;
	localparam logic [11:0] IRQ_MASK = 12'h404;
	localparam logic [11:0] PORT_STATE = 12'h408;
	localparam int CH_BITS = 8;
	localparam int LINK_EN_BIT = 31;
	localparam int NUM_TASKS = 5;
	localparam int NUM_EVENTS = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Task indices, also the channel link order.
	localparam int T_RXSTART = 0;
	localparam int T_RXSTOP = 1;
	localparam int T_TXSTART = 2;
	localparam int T_TXSTOP = 3;
	localparam int T_DRAIN = 4;
	// Event indices, also the interrupt status bit order.
	localparam int E_READY = 0;
	localparam int E_NOTREADY = 1;
	localparam int E_RXBYTE = 2;
	localparam int E_RXFULL = 3;
	localparam int E_TXBYTE = 4;
	localparam int E_TXDONE = 5;
endpackage

//--- testbench/spt_regs_monitor.sv
`timescale 1ns/100ps
module spt_regs_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rxStartPulse,
	input wire logic rxStopPulse,
	input wire logic txStartPulse,
	input wire logic txStopPulse,
	input wire logic rxRunning,
	input wire logic txRunning,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_write_answer: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	chk_read_answer: assert property (rdTaken |-> ##[1:2] s_axi_rvalid)
		else $error("read response late");
	chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	chk_write_refused: assert property (!s_axi_awready && !s_axi_wready && !s_axi_bvalid |=> s_axi_bvalid)
		else $error("held write not answered");
	chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	chk_rx_start: assert property (rxStartPulse && !rxStopPulse |-> ##[0:1] rxRunning)
		else $error("receiver did not start");
	chk_rx_stop: assert property (rxStopPulse |-> ##[0:1] !rxRunning)
		else $error("receiver did not stop");
	chk_tx_start: assert property (txStartPulse && !txStopPulse |-> ##[0:1] txRunning)
		else $error("transmitter did not start");
	chk_tx_stop: assert property (txStopPulse |-> ##[0:1] !txRunning)
		else $error("transmitter did not stop");
	chk_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !s_axi_bvalid && !irq && !rxRunning)
		else $error("outputs active after reset");
endmodule
bind spt_regs spt_regs_monitor u_spt_regs_monitor (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rxStartPulse, .rxStopPulse, .txStartPulse,
	.txStopPulse, .rxRunning, .txRunning, .irq);

//--- testbench/spt_line_peer.sv
`timescale 1ns/100ps
module spt_line_peer (
	input wire logic clk,
	input wire logic txRunning,
	output logic ctsPin_n,
	output logic [3:0] strobes
);
	initial begin
		ctsPin_n = 1'b1;
		strobes = 4'h0;
	end
	// Three cycles high, then six low, so the edge detector behind the sync sees each strobe.
	task automatic strobe(input int idx);
		repeat (3) @(posedge clk);
		strobes[idx] <= 1'b1;
		repeat (3) @(posedge clk);
		strobes[idx] <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task automatic setCts(input logic lvl);
		@(posedge clk);
		ctsPin_n <= lvl;
		repeat (8) @(posedge clk);
	endtask
	// A started transmitter sends one byte, which is also the last of its buffer.
	always begin
		@(posedge clk);
		if (txRunning === 1'b1) begin
			strobe(2);
			strobe(3);
		end
	end
endmodule

//--- testbench/test_serial_port_task_event_regs.sv
`timescale 1ns/100ps
module test_serial_port_task_event_regs;
	logic clk, rst_n, awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady;
	logic rValid, rReady, ctsN, drain, rxRun, txRun, irq;
	logic [11:0] awAddr, arAddr;
	logic [31:0] wData, rData, v;
	logic [3:0] wStrb, strobes;
	logic [1:0] bResp, rResp, r;
	logic [255:0] chEv;
	int fails, tests_run, cyc, drains;
	spt_regs u_spt_regs (.clk, .rst_n, .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.channelEvents(chEv), .ctsPin_n(ctsN), .rxByteLanded(strobes[0]),
		.rxBufferFilled(strobes[1]), .txByteSent(strobes[2]), .txLastByteSent(strobes[3]),
		.rxStartPulse(), .rxStopPulse(), .txStartPulse(), .txStopPulse(), .rxDrainPulse(drain),
		.rxRunning(rxRun), .txRunning(txRun), .irq);
	spt_line_peer u_spt_line_peer (.clk, .txRunning(txRun), .ctsPin_n(ctsN), .strobes);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Far beyond the few hundred cycles the sequence needs.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	always @(negedge clk)
		if (drain === 1'b1)
			drains++;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic aDone, wDone, aNow, wNow;
		aDone = 1'b0;
		wDone = 1'b0;
		@(posedge clk);
		{awAddr, wData, awValid, wValid, bReady} <= {a, d, 3'b111};
		// Each channel is released at the edge that takes it, in whichever order.
		do begin
			@(negedge clk);
			aNow = !aDone && awReady === 1'b1;
			wNow = !wDone && wReady === 1'b1;
			@(posedge clk);
			if (aNow)
				awValid <= 1'b0;
			if (wNow)
				wValid <= 1'b0;
			aDone = aDone | aNow;
			wDone = wDone | wNow;
		end while (!(aDone && wDone));
		do @(negedge clk); while (bValid !== 1'b1);
		r = bResp;
		@(posedge clk);
		bReady <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		{arAddr, arValid, rReady} <= {a, 2'b11};
		do @(negedge clk); while (arReady !== 1'b1);
		@(posedge clk);
		arValid <= 1'b0;
		do @(negedge clk); while (rValid !== 1'b1);
		{v, r} = {rData, rResp};
		@(posedge clk);
		rReady <= 1'b0;
	endtask
	task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, v);
	endtask
	task automatic st(input logic [1:0] e);
		rd(spt_pkg::PORT_STATE);
		chk("running", {30'h0, e}, {30'h0, v[1:0]});
	endtask
	task automatic ci(input logic e);
		@(negedge clk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask
	task automatic ev(input int n);
		@(posedge clk);
		chEv[n] <= 1'b1;
		@(posedge clk);
		chEv <= '0;
		repeat (3) @(posedge clk);
	endtask
	logic [11:0] flagA [6] = '{12'h100, 12'h104, 12'h108, 12'h110, 12'h11c, 12'h120};
	logic [11:0] linkA [5] = '{12'h080, 12'h084, 12'h088, 12'h08c, 12'h0ac};
	initial begin
		{awValid, wValid, bReady, arValid, rReady, awAddr, arAddr, wData, chEv, rst_n} = '0;
		{fails, tests_run, cyc, drains} = '0;
		wStrb = 4'hf;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		foreach (flagA[i])
			rc("flag reset", flagA[i], 32'h0);
		rc("task read", spt_pkg::RX_START_TRIGGER, 32'h0);
		wr(spt_pkg::RX_START_TRIGGER, 32'h0);
		st(2'h0);
		wr(spt_pkg::RX_START_TRIGGER, 32'h1);
		st(2'h1);
		wr(spt_pkg::RX_STOP_TRIGGER, 32'h1);
		st(2'h0);
		wr(spt_pkg::TX_START_TRIGGER, 32'h1);
		wr(spt_pkg::TX_STOP_TRIGGER, 32'h1);
		st(2'h0);
		wr(spt_pkg::RX_FIFO_DRAIN_TRIGGER, 32'h1);
		wr(spt_pkg::RX_FIFO_DRAIN_TRIGGER, 32'h0);
		chk("drains", 32'h1, 32'(drains));
		foreach (linkA[i])
			wr(linkA[i], 32'h10 + i);
		foreach (linkA[i])
			rc("link", linkA[i], 32'h10 + i);
		wr(spt_pkg::RX_START_CHANNEL_LINK, 32'h8000_0005);
		ev(5);
		st(2'h1);
		ev(17);
		st(2'h1);
		wr(spt_pkg::RX_STOP_CHANNEL_LINK, 32'h8000_0011);
		ev(17);
		st(2'h0);
		// Highest channel index drives the transmitter start.
		wr(spt_pkg::TX_START_CHANNEL_LINK, 32'h8000_00ff);
		ev(255);
		st(2'h2);
		while (txRun === 1'b1)
			@(posedge clk);
		repeat (24) @(posedge clk);
		rc("byte sent", spt_pkg::BYTE_SENT_FLAG, 32'h1);
		rc("tx done", spt_pkg::TX_DONE_FLAG, 32'h1);
		wr(12'h200, 32'h1);
		chk("bresp", {30'h0, spt_pkg::RESP_SLVERR}, {30'h0, r});
		rd(12'h200);
		chk("rresp", {30'h0, spt_pkg::RESP_SLVERR}, {30'h0, r});
		rd(spt_pkg::IRQ_STATUS);
		wr(spt_pkg::IRQ_MASK, 32'h4);
		wr(spt_pkg::RX_START_TRIGGER, 32'h1);
		u_spt_line_peer.setCts(1'b0);
		ci(1'b0);
		u_spt_line_peer.strobe(0);
		ci(1'b1);
		rc("status", spt_pkg::IRQ_STATUS, 32'h5);
		ci(1'b0);
		u_spt_line_peer.setCts(1'b1);
		u_spt_line_peer.strobe(1);
		st(2'h0);
		foreach (flagA[i])
			if (i < 4)
				rc("flag set", flagA[i], 32'h1);
		wr(spt_pkg::BYTE_RECEIVED_FLAG, 32'h0);
		rc("flag clear", spt_pkg::BYTE_RECEIVED_FLAG, 32'h0);
		wr(spt_pkg::PEER_READY_FLAG, 32'h1);
		rc("flag write one", spt_pkg::PEER_READY_FLAG, 32'h1);
		stop_test();
	end
endmodule
